// ===== rtl/prio_regs_pkg.sv
// Constants for the interrupt priority register bank.
package prio_regs_pkg;
  localparam logic [11:0] OFF_EXT_INT1 = 12'h000;
  localparam logic [11:0] OFF_TIMER4 = 12'h004;
  localparam logic [11:0] OFF_EXT_INT2_TIMER5 = 12'h008;
  localparam logic [11:0] OFF_CAPTURE3 = 12'h00C;
  localparam logic [11:0] OFF_PWM = 12'h010;
  localparam logic [11:0] OFF_FAULT_A_RTC = 12'h014;
  localparam logic [11:0] OFF_UART_ERR_FAULT_B = 12'h018;
  localparam int POS_EXT_INT1 = 0;
  localparam int POS_TIMER4 = 12;
  localparam int POS_EXT_INT2 = 4;
  localparam int POS_TIMER5 = 0;
  localparam int POS_CAPTURE3 = 4;
  localparam int POS_PWM = 4;
  localparam int POS_FAULT_A = 12;
  localparam int POS_RTC = 8;
  localparam int POS_UART_ERROR = 4;
  localparam int POS_FAULT_B = 0;
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
endpackage : prio_regs_pkg

// ===== rtl/interrupt_priority_regs.sv
// APB register bank holding the per-source interrupt priority fields.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_regs
  import prio_regs_pkg::*;
#(
  parameter bit HAS_LARGE_MEM = 1'b1,
  parameter bit HAS_MOTOR = 1'b1,
  parameter bit HAS_FAULT_B = 1'b1
)
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [2:0] ext_int1_level_out,
  output logic [2:0] timer4_level_out,
  output logic [2:0] ext_int2_level_out,
  output logic [2:0] timer5_level_out,
  output logic [2:0] capture3_level_out,
  output logic [2:0] pwm_level_out,
  output logic [2:0] fault_a_level_out,
  output logic [2:0] rtc_level_out,
  output logic [2:0] uart_error_level_out,
  output logic [2:0] fault_b_level_out,
  output logic [9:0] source_enabled_out
);

  typedef struct packed {
    logic [2:0] ext_int1_level;
    logic [2:0] timer4_level;
    logic [2:0] ext_int2_level;
    logic [2:0] timer5_level;
    logic [2:0] capture3_level;
    logic [2:0] pwm_level;
    logic [2:0] fault_a_level;
    logic [2:0] rtc_level;
    logic [2:0] uart_error_level;
    logic [2:0] fault_b_level;
    logic [31:0] rdata;
    logic rd_done;
  } state_s;

  state_s state_q;
  state_s state_d;
  logic access;
  logic wr;
  logic [15:0] rd_word;
  logic hit;
  logic [29:0] levels;

  // A field is written only when the byte lane holding it is strobed.
  function automatic logic [2:0] field_wr(input logic [2:0] cur, input int pos,
                                          input logic [31:0] data, input logic [3:0] strb);
    logic [2:0] res;
    res = cur;
    if (strb[pos / 8])
    begin
      res = data[pos +: 3];
    end
    return res;
  endfunction : field_wr

  assign access = psel_in && penable_in;
  assign wr = access && pwrite_in;
  // Writes finish in the first access cycle. Reads take one wait state, so the
  // read data can come from a flip-flop and still stand at the completion edge.
  assign pready_out = !(access && !pwrite_in) || state_q.rd_done;

  always_comb
  begin
    hit = 1'b1;
    rd_word = 16'h0000;
    unique case (paddr_in)
      OFF_EXT_INT1: rd_word[POS_EXT_INT1 +: 3] = state_q.ext_int1_level;
      OFF_TIMER4: rd_word[POS_TIMER4 +: 3] = state_q.timer4_level;
      OFF_EXT_INT2_TIMER5:
      begin
        rd_word[POS_EXT_INT2 +: 3] = state_q.ext_int2_level;
        rd_word[POS_TIMER5 +: 3] = state_q.timer5_level;
      end
      OFF_CAPTURE3: rd_word[POS_CAPTURE3 +: 3] = state_q.capture3_level;
      OFF_PWM: rd_word[POS_PWM +: 3] = state_q.pwm_level;
      OFF_FAULT_A_RTC:
      begin
        rd_word[POS_FAULT_A +: 3] = state_q.fault_a_level;
        rd_word[POS_RTC +: 3] = state_q.rtc_level;
      end
      OFF_UART_ERR_FAULT_B:
      begin
        rd_word[POS_UART_ERROR +: 3] = state_q.uart_error_level;
        rd_word[POS_FAULT_B +: 3] = state_q.fault_b_level;
      end
      default: hit = 1'b0;
    endcase
  end

  assign pslverr_out = access && !hit && pready_out;

  always_comb
  begin
    state_d = state_q;
    state_d.rd_done = access && !pwrite_in && !state_q.rd_done;
    if (access && !pwrite_in && !state_q.rd_done)
    begin
      state_d.rdata = {16'h0000, rd_word};
    end
    if (wr && hit)
    begin
      unique case (paddr_in)
        OFF_EXT_INT1:
          state_d.ext_int1_level = field_wr(state_q.ext_int1_level, POS_EXT_INT1,
                                            pwdata_in, pstrb_in);
        OFF_TIMER4:
          state_d.timer4_level = field_wr(state_q.timer4_level, POS_TIMER4,
                                          pwdata_in, pstrb_in);
        OFF_EXT_INT2_TIMER5:
        begin
          state_d.ext_int2_level = field_wr(state_q.ext_int2_level, POS_EXT_INT2,
                                            pwdata_in, pstrb_in);
          state_d.timer5_level = field_wr(state_q.timer5_level, POS_TIMER5,
                                          pwdata_in, pstrb_in);
        end
        OFF_CAPTURE3:
          state_d.capture3_level = field_wr(state_q.capture3_level, POS_CAPTURE3,
                                            pwdata_in, pstrb_in);
        OFF_PWM:
          state_d.pwm_level = field_wr(state_q.pwm_level, POS_PWM,
                                       pwdata_in, pstrb_in);
        OFF_FAULT_A_RTC:
        begin
          state_d.fault_a_level = field_wr(state_q.fault_a_level, POS_FAULT_A,
                                           pwdata_in, pstrb_in);
          state_d.rtc_level = field_wr(state_q.rtc_level, POS_RTC,
                                       pwdata_in, pstrb_in);
        end
        default:
        begin
          state_d.uart_error_level = field_wr(state_q.uart_error_level, POS_UART_ERROR,
                                              pwdata_in, pstrb_in);
          state_d.fault_b_level = field_wr(state_q.fault_b_level, POS_FAULT_B,
                                           pwdata_in, pstrb_in);
        end
      endcase
    end
    // Absent sources are pinned at zero so they read back zero and never request.
    if (!HAS_LARGE_MEM)
    begin
      state_d.timer4_level = LEVEL_OFF;
      state_d.timer5_level = LEVEL_OFF;
    end
    if (!HAS_MOTOR)
    begin
      state_d.pwm_level = LEVEL_OFF;
      state_d.fault_a_level = LEVEL_OFF;
    end
    if (!HAS_FAULT_B)
    begin
      state_d.fault_b_level = LEVEL_OFF;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_q.ext_int1_level <= LEVEL_RESET;
      state_q.timer4_level <= HAS_LARGE_MEM ? LEVEL_RESET : LEVEL_OFF;
      state_q.ext_int2_level <= LEVEL_RESET;
      state_q.timer5_level <= HAS_LARGE_MEM ? LEVEL_RESET : LEVEL_OFF;
      state_q.capture3_level <= LEVEL_RESET;
      state_q.pwm_level <= HAS_MOTOR ? LEVEL_RESET : LEVEL_OFF;
      state_q.fault_a_level <= HAS_MOTOR ? LEVEL_RESET : LEVEL_OFF;
      state_q.rtc_level <= LEVEL_RESET;
      state_q.uart_error_level <= LEVEL_RESET;
      state_q.fault_b_level <= LEVEL_OFF;
      state_q.rdata <= 32'h0000_0000;
      state_q.rd_done <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Read data is loaded in the wait state and stands at the completion edge.
  assign prdata_out = state_q.rdata;

  assign levels = {state_q.fault_b_level, state_q.uart_error_level, state_q.rtc_level,
                   state_q.fault_a_level, state_q.pwm_level, state_q.capture3_level,
                   state_q.timer5_level, state_q.ext_int2_level, state_q.timer4_level,
                   state_q.ext_int1_level};

  // The arbiter sees the raw code; it is the numeric level itself.
  assign ext_int1_level_out = state_q.ext_int1_level;
  assign timer4_level_out = state_q.timer4_level;
  assign ext_int2_level_out = state_q.ext_int2_level;
  assign timer5_level_out = state_q.timer5_level;
  assign capture3_level_out = state_q.capture3_level;
  assign pwm_level_out = state_q.pwm_level;
  assign fault_a_level_out = state_q.fault_a_level;
  assign rtc_level_out = state_q.rtc_level;
  assign uart_error_level_out = state_q.uart_error_level;
  assign fault_b_level_out = state_q.fault_b_level;

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++)
    begin : g_en
      // Level 000 masks the source; 001 to 111 are levels 1 to 7.
      assign source_enabled_out[gi] = (levels[gi*3 +: 3] != LEVEL_OFF);
    end
  endgenerate

  a_write_lands: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr && paddr_in == OFF_EXT_INT1 && pstrb_in[0]
    |=> ext_int1_level_out == $past(pwdata_in[2:0]))
    else $error("ext int1 level did not take written value");
  a_read_zero_bits: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in |=> prdata_out[31:15] == 17'h0 && prdata_out[11] == 1'b0
    && prdata_out[7] == 1'b0 && prdata_out[3] == 1'b0)
    else $error("unimplemented bit read as one");
  a_level7_enabled: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    rtc_level_out == 3'h7 |-> source_enabled_out[7])
    else $error("level 7 source not enabled");
  a_level1_enabled: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    capture3_level_out == 3'h1 |-> source_enabled_out[4])
    else $error("level 1 source not enabled");
  a_zero_disables: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    uart_error_level_out == 3'h0 |-> !source_enabled_out[8])
    else $error("level 0 source enabled");
  a_pair_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_FAULT_A_RTC
    |=> prdata_out[10:8] == rtc_level_out && prdata_out[7:0] == 8'h00)
    else $error("clock field readback wrong");
  a_reset_level: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> ext_int1_level_out == 3'h4 && fault_b_level_out == 3'h0)
    else $error("reset levels wrong");
  a_absent_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !HAS_MOTOR |-> pwm_level_out == 3'h0 && fault_a_level_out == 3'h0)
    else $error("absent source holds a level");
  a_held_idle: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !wr |=> $stable(timer5_level_out) && $stable(ext_int2_level_out))
    else $error("level changed without a write");

  a_read_wait: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && !pready_out |=> pready_out)
    else $error("read wait state did not end");

  a_write_no_wait: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr |-> pready_out)
    else $error("write was made to wait");

  a_unmapped_error: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && paddr_in == 12'h01C && pready_out |-> pslverr_out)
    else $error("unmapped word did not refuse");

  a_timer4_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    HAS_LARGE_MEM && wr && paddr_in == OFF_TIMER4 && pstrb_in[1]
    |=> timer4_level_out == $past(pwdata_in[14:12]))
    else $error("timer 4 level did not take written value");

  a_ext_int2_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr && paddr_in == OFF_EXT_INT2_TIMER5 && pstrb_in[0]
    |=> ext_int2_level_out == $past(pwdata_in[6:4]))
    else $error("ext int2 level did not take written value");

  a_timer5_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    HAS_LARGE_MEM && wr && paddr_in == OFF_EXT_INT2_TIMER5 && pstrb_in[0]
    |=> timer5_level_out == $past(pwdata_in[2:0]))
    else $error("timer 5 level did not take written value");

  a_capture3_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr && paddr_in == OFF_CAPTURE3 && pstrb_in[0]
    |=> capture3_level_out == $past(pwdata_in[6:4]))
    else $error("capture 3 level did not take written value");

  a_pwm_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    HAS_MOTOR && wr && paddr_in == OFF_PWM && pstrb_in[0]
    |=> pwm_level_out == $past(pwdata_in[6:4]))
    else $error("pwm level did not take written value");

  a_fault_a_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    HAS_MOTOR && wr && paddr_in == OFF_FAULT_A_RTC && pstrb_in[1]
    |=> fault_a_level_out == $past(pwdata_in[14:12]))
    else $error("fault A level did not take written value");

  a_rtc_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr && paddr_in == OFF_FAULT_A_RTC && pstrb_in[1]
    |=> rtc_level_out == $past(pwdata_in[10:8]))
    else $error("calendar level did not take written value");

  a_uart_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    wr && paddr_in == OFF_UART_ERR_FAULT_B && pstrb_in[0]
    |=> uart_error_level_out == $past(pwdata_in[6:4]))
    else $error("uart error level did not take written value");

  a_fault_b_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    HAS_FAULT_B && wr && paddr_in == OFF_UART_ERR_FAULT_B && pstrb_in[0]
    |=> fault_b_level_out == $past(pwdata_in[2:0]))
    else $error("fault B level did not take written value");

  a_int1_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_EXT_INT1 && !pready_out
    |=> prdata_out == {29'h0, ext_int1_level_out})
    else $error("ext int1 readback wrong");

  a_timer4_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_TIMER4 && !pready_out
    |=> prdata_out == {17'h0, timer4_level_out, 12'h000})
    else $error("timer 4 readback wrong");

  a_pair7_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_EXT_INT2_TIMER5 && !pready_out
    |=> prdata_out == {25'h0, ext_int2_level_out, 1'b0, timer5_level_out})
    else $error("ext int2 and timer 5 readback wrong");

  a_capture3_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_CAPTURE3 && !pready_out
    |=> prdata_out == {25'h0, capture3_level_out, 4'h0})
    else $error("capture 3 readback wrong");

  a_pwm_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_PWM && !pready_out
    |=> prdata_out == {25'h0, pwm_level_out, 4'h0})
    else $error("pwm readback wrong");

  a_pair16_readback: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    access && !pwrite_in && paddr_in == OFF_UART_ERR_FAULT_B && !pready_out
    |=> prdata_out == {25'h0, uart_error_level_out, 1'b0, fault_b_level_out})
    else $error("uart error and fault B readback wrong");

  a_reset_default: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> rtc_level_out == 3'h4 && capture3_level_out == 3'h4)
    else $error("source did not reset to level 4");

endmodule : interrupt_priority_regs
`default_nettype wire

// ===== dv/interrupt_priority_regs_tb_top.sv
// Self-checking bench for the interrupt priority register bank.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_regs_tb_top
  import prio_regs_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [2:0] lv [10];
  logic [9:0] en;
  int miscompares = 0;
  int n_checks = 0;
  int mdl [7];
  localparam logic [15:0] MASK [7] = '{16'h0007, 16'h7000, 16'h0077, 16'h0070, 16'h0070,
    16'h7700, 16'h0077};
  localparam logic [15:0] RSTV [7] = '{16'h0004, 16'h4000, 16'h0044, 16'h0040, 16'h0040,
    16'h4400, 16'h0040};
  localparam logic [11:0] ADDR [7] = '{OFF_EXT_INT1, OFF_TIMER4, OFF_EXT_INT2_TIMER5,
    OFF_CAPTURE3, OFF_PWM, OFF_FAULT_A_RTC, OFF_UART_ERR_FAULT_B};
  localparam int SRC_REG [10] = '{0, 1, 2, 2, 3, 4, 5, 5, 6, 6};
  localparam int SRC_POS [10] = '{0, 12, 4, 0, 4, 4, 12, 8, 4, 0};

  interrupt_priority_regs uut (
    .sys_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .ext_int1_level_out(lv[0]), .timer4_level_out(lv[1]), .ext_int2_level_out(lv[2]),
    .timer5_level_out(lv[3]), .capture3_level_out(lv[4]), .pwm_level_out(lv[5]),
    .fault_a_level_out(lv[6]), .rtc_level_out(lv[7]), .uart_error_level_out(lv[8]),
    .fault_b_level_out(lv[9]), .source_enabled_out(en)
  );

  task automatic print_verdict();
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The answer is awaited under a bound, so a stuck slave ends the run.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 8);
    if (n >= 8)
    begin
      miscompares++;
      print_verdict();
    end
    // Response and read data are taken at the edge that saw pready high.
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, ADDR[i], d, s);
    chk(32'(err), 32'h0);
    if (s == 4'hF)
      mdl[i] = int'(d[15:0] & MASK[i]);
  endtask : wr_reg

  task automatic check_all();
    logic [2:0] e;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, ADDR[i], 32'h0, 4'h0);
      chk(rd, 32'(mdl[i]));
    end
    for (int k = 0; k < 10; k++)
    begin
      e = 3'(mdl[SRC_REG[k]] >> SRC_POS[k]);
      chk(32'(lv[k]), 32'(e));
      chk(32'(en[k]), 32'(e != 3'h0));
    end
  endtask : check_all

  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++)
      mdl[i] = int'(RSTV[i]);
  endtask : do_reset

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    int i;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    void'($urandom(32'h671bdeb1));
    do_reset();
    check_all();
    // Every code into every field, including the disabling code.
    for (int c = 0; c < 8; c++)
    begin
      for (int r = 0; r < 7; r++)
        wr_reg(r, {8{4'(c)}}, 4'hF);
      check_all();
    end
    // An unmapped word refuses and a write with no strobes changes nothing.
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF, 4'hF);
    chk(32'(err), 32'h1);
    apb(1'b0, 12'h01C, 32'h0, 4'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    wr_reg(3, 32'h0000_0000, 4'h0);
    check_all();
    // Random patterns also hit every unimplemented bit.
    repeat (40)
    begin
      i = int'($urandom_range(6));
      wr_reg(i, $urandom, 4'hF);
      check_all();
    end
    // A second reset in mid-run restores the power-on levels.
    do_reset();
    check_all();
    print_verdict();
  end
endmodule : interrupt_priority_regs_tb_top
`default_nettype wire
